//--- inc/jfc_pkg.sv
/*
 * Shared constants and types for the test-port fuse check control block.
 * Assumes a single system clock domain (mclk) and a test clock domain (tck).
 */
package jfc_pkg;

    // --------------------------------------------------------------
    // synchroniser and edge counting
    // --------------------------------------------------------------
    localparam int         SYNC_STAGES   = 2;
    localparam logic [1:0] RISE_CNT_INIT = 2'h0;
    localparam logic [1:0] RISE_DEACT    = 2'h2;
    localparam logic [1:0] RISE_ONE      = 2'h1;

    // --------------------------------------------------------------
    // pin idle levels and the safe lock level seen before the first synchronised sample
    // --------------------------------------------------------------
    localparam logic TMS_IDLE   = 1'b1;
    localparam logic SENSE_IDLE = 1'b0;
    localparam logic FUSE_IDLE  = 1'b0;
    localparam logic LOCK_SAFE  = 1'b1;

    // --------------------------------------------------------------
    // test access port
    // --------------------------------------------------------------
    localparam int              IR_W       = 4;
    localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic            BYP_CAPT   = 1'b0;

    // --------------------------------------------------------------
    // loader access key
    // --------------------------------------------------------------
    localparam int KEY_W = 256;

    typedef enum logic [1:0] {
        CHK_ARMED,
        CHK_ACTIVE,
        CHK_DONE
    } jfc_chk_state_t;

    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } jfc_tap_state_t;

    typedef struct packed {
        logic check_active;
        logic sense_en;
        logic port_locked;
        logic mem_protect;
    } jfc_status_t;

    typedef struct packed {
        logic             valid;
        logic [KEY_W-1:0] key;
    } jfc_key_req_t;

endpackage

//--- hw/jfc_sync.sv
/*
 * Multi-bit level synchroniser: each bit passes a chain of flip-flops.
 * Assumes bits are independent levels; no word coherence is promised.
 */
`timescale 1ns/100ps
module jfc_sync #(
    parameter int           W       = 1,
    parameter int           STAGES  = jfc_pkg::SYNC_STAGES,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [STAGES-1:0][W-1:0] chain;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            chain <= {STAGES{RST_VAL}};
        end
        else
        begin
            chain <= {chain[STAGES-2:0], d};
        end
    end

    assign q = chain[STAGES-1];

endmodule

//--- hw/jfc_top.sv
/*
 * Test-port fuse check control: arms and ends fuse check mode from the
 * mode-select line, gates the fuse sense current, locks the test port into
 * bypass once the fuse is blown, and grants loader access by key.
 * Assumes reset is the power-on reset of the device and tck is the test
 * clock of the external debugger, unrelated to mclk and possibly stopped.
 */
`timescale 1ns/100ps
module jfc_top #(
    parameter int KEY_W = jfc_pkg::KEY_W
)
(
    // system clock and power-on reset
    input  wire logic                 mclk,
    input  wire logic                 reset,
    // test link, clocked by the debugger
    input  wire logic                 tck,
    input  wire logic                 tms_pin,
    input  wire logic                 tdi_pin,
    output logic                      tdo,
    output logic                      tdo_oe,
    // fuse pins
    input  wire logic                 sense_pin,
    input  wire logic                 fuse_blown_pin,
    // on-chip test logic behind the port, tck domain
    input  wire logic                 core_tdo,
    output logic                      core_debug_en,
    output logic [jfc_pkg::IR_W-1:0]  core_ir,
    // loader key check, mclk domain
    input  wire jfc_pkg::jfc_key_req_t key_req,
    input  wire logic [KEY_W-1:0]     key_ref,
    output logic                      loader_grant,
    // status
    output jfc_pkg::jfc_status_t      status
);

    // ----------------------------------------------------------------
    // pin synchronisers, mclk domain
    // ----------------------------------------------------------------
    logic tms_s;
    logic sense_s;
    logic fuse_s;

    jfc_sync #(
        .W       (1),
        .RST_VAL (jfc_pkg::TMS_IDLE)
    ) u_sync_tms (
        .clk (mclk),
        .rst (reset),
        .d   (tms_pin),
        .q   (tms_s)
    );

    jfc_sync #(
        .W       (1),
        .RST_VAL (jfc_pkg::SENSE_IDLE)
    ) u_sync_sense (
        .clk (mclk),
        .rst (reset),
        .d   (sense_pin),
        .q   (sense_s)
    );

    jfc_sync #(
        .W       (1),
        .RST_VAL (jfc_pkg::FUSE_IDLE)
    ) u_sync_fuse (
        .clk (mclk),
        .rst (reset),
        .d   (fuse_blown_pin),
        .q   (fuse_s)
    );

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic tms_q;
    logic sense_q;
    logic tms_fall;
    logic tms_rise;
    logic sense_fall;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            tms_q   <= jfc_pkg::TMS_IDLE;
            sense_q <= jfc_pkg::SENSE_IDLE;
        end
        else
        begin
            tms_q   <= tms_s;
            sense_q <= sense_s;
        end
    end

    // idle-high reset of the chain turns tms held low at power-up
    // into a falling edge once the chain fills
    assign tms_fall   = tms_q & ~tms_s;
    assign tms_rise   = ~tms_q & tms_s;
    assign sense_fall = sense_q & ~sense_s;

    // ----------------------------------------------------------------
    // rising-edge counter since power-up
    // ----------------------------------------------------------------
    logic [1:0] rise_cnt;
    logic       second_rise;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rise_cnt <= jfc_pkg::RISE_CNT_INIT;
        end
        else if (tms_rise && rise_cnt != jfc_pkg::RISE_DEACT)
        begin
            rise_cnt <= rise_cnt + jfc_pkg::RISE_ONE;
        end
    end

    assign second_rise = tms_rise && (rise_cnt == jfc_pkg::RISE_DEACT - jfc_pkg::RISE_ONE);

    // ----------------------------------------------------------------
    // fuse check mode
    // ----------------------------------------------------------------
    jfc_pkg::jfc_chk_state_t chk_state;
    jfc_pkg::jfc_chk_state_t next_chk_state;

    always_comb
    begin
        next_chk_state = chk_state;
        unique case (chk_state)
            jfc_pkg::CHK_ARMED:
            begin
                if (second_rise)
                begin
                    next_chk_state = jfc_pkg::CHK_DONE;
                end
                else if (tms_fall)
                begin
                    next_chk_state = jfc_pkg::CHK_ACTIVE;
                end
            end
            jfc_pkg::CHK_ACTIVE:
            begin
                if (second_rise)
                begin
                    next_chk_state = jfc_pkg::CHK_DONE;
                end
                else if (sense_fall)
                begin
                    next_chk_state = jfc_pkg::CHK_DONE;
                end
            end
            jfc_pkg::CHK_DONE:
            begin
                next_chk_state = jfc_pkg::CHK_DONE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            chk_state <= jfc_pkg::CHK_ARMED;
        end
        else
        begin
            chk_state <= next_chk_state;
        end
    end

    // ----------------------------------------------------------------
    // fuse lock, held until power-on reset
    // ----------------------------------------------------------------
    logic locked;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            locked <= jfc_pkg::FUSE_IDLE;
        end
        else if (fuse_s)
        begin
            locked <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------
    jfc_pkg::jfc_status_t next_status;

    always_comb
    begin
        next_status              = '0;
        next_status.check_active = (next_chk_state == jfc_pkg::CHK_ACTIVE);
        next_status.sense_en     = next_status.check_active & ~tms_s;
        next_status.port_locked  = locked | fuse_s;
        next_status.mem_protect  = locked | fuse_s;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            status <= '0;
        end
        else
        begin
            status <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // loader key check
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            loader_grant <= 1'b0;
        end
        else
        begin
            loader_grant <= key_req.valid && (key_req.key == key_ref);
        end
    end

    // ----------------------------------------------------------------
    // crossing into the tck domain
    // ----------------------------------------------------------------
    logic tck_rst;
    logic lock_t;

    jfc_sync #(
        .W       (1),
        .RST_VAL (1'b1)
    ) u_sync_rst (
        .clk (tck),
        .rst (1'b0),
        .d   (reset),
        .q   (tck_rst)
    );

    jfc_sync #(
        .W       (1),
        .RST_VAL (jfc_pkg::LOCK_SAFE)
    ) u_sync_lock (
        .clk (tck),
        .rst (tck_rst),
        .d   (status.port_locked),
        .q   (lock_t)
    );

    // ----------------------------------------------------------------
    // test port controller, tck domain
    // ----------------------------------------------------------------
    jfc_pkg::jfc_tap_state_t tap_state;
    jfc_pkg::jfc_tap_state_t next_tap_state;

    always_comb
    begin
        next_tap_state = tap_state;
        unique case (tap_state)
            jfc_pkg::TAP_RESET:    next_tap_state = tms_pin ? jfc_pkg::TAP_RESET  : jfc_pkg::TAP_IDLE;
            jfc_pkg::TAP_IDLE:     next_tap_state = tms_pin ? jfc_pkg::TAP_SEL_DR : jfc_pkg::TAP_IDLE;
            jfc_pkg::TAP_SEL_DR:   next_tap_state = tms_pin ? jfc_pkg::TAP_SEL_IR : jfc_pkg::TAP_CAP_DR;
            jfc_pkg::TAP_CAP_DR:   next_tap_state = tms_pin ? jfc_pkg::TAP_EXIT1_DR : jfc_pkg::TAP_SHIFT_DR;
            jfc_pkg::TAP_SHIFT_DR: next_tap_state = tms_pin ? jfc_pkg::TAP_EXIT1_DR : jfc_pkg::TAP_SHIFT_DR;
            jfc_pkg::TAP_EXIT1_DR: next_tap_state = tms_pin ? jfc_pkg::TAP_UPD_DR : jfc_pkg::TAP_PAUSE_DR;
            jfc_pkg::TAP_PAUSE_DR: next_tap_state = tms_pin ? jfc_pkg::TAP_EXIT2_DR : jfc_pkg::TAP_PAUSE_DR;
            jfc_pkg::TAP_EXIT2_DR: next_tap_state = tms_pin ? jfc_pkg::TAP_UPD_DR : jfc_pkg::TAP_SHIFT_DR;
            jfc_pkg::TAP_UPD_DR:   next_tap_state = tms_pin ? jfc_pkg::TAP_SEL_DR : jfc_pkg::TAP_IDLE;
            jfc_pkg::TAP_SEL_IR:   next_tap_state = tms_pin ? jfc_pkg::TAP_RESET  : jfc_pkg::TAP_CAP_IR;
            jfc_pkg::TAP_CAP_IR:   next_tap_state = tms_pin ? jfc_pkg::TAP_EXIT1_IR : jfc_pkg::TAP_SHIFT_IR;
            jfc_pkg::TAP_SHIFT_IR: next_tap_state = tms_pin ? jfc_pkg::TAP_EXIT1_IR : jfc_pkg::TAP_SHIFT_IR;
            jfc_pkg::TAP_EXIT1_IR: next_tap_state = tms_pin ? jfc_pkg::TAP_UPD_IR : jfc_pkg::TAP_PAUSE_IR;
            jfc_pkg::TAP_PAUSE_IR: next_tap_state = tms_pin ? jfc_pkg::TAP_EXIT2_IR : jfc_pkg::TAP_PAUSE_IR;
            jfc_pkg::TAP_EXIT2_IR: next_tap_state = tms_pin ? jfc_pkg::TAP_UPD_IR : jfc_pkg::TAP_SHIFT_IR;
            jfc_pkg::TAP_UPD_IR:   next_tap_state = tms_pin ? jfc_pkg::TAP_SEL_DR : jfc_pkg::TAP_IDLE;
        endcase
    end

    // controller reset leaves the fuse check state untouched
    always_ff @(posedge tck)
    begin
        if (tck_rst)
        begin
            tap_state <= jfc_pkg::TAP_RESET;
        end
        else
        begin
            tap_state <= next_tap_state;
        end
    end

    // ----------------------------------------------------------------
    // instruction and bypass registers
    // ----------------------------------------------------------------
    logic [jfc_pkg::IR_W-1:0] ir_shift;
    logic [jfc_pkg::IR_W-1:0] next_ir_shift;
    logic                     byp_bit;
    logic                     next_byp_bit;
    logic                     sel_core;

    always_ff @(posedge tck)
    begin
        if (tck_rst)
        begin
            ir_shift <= jfc_pkg::IR_CAPTURE;
            core_ir  <= jfc_pkg::IR_BYPASS;
        end
        else
        begin
            ir_shift <= next_ir_shift;
            // lock forces bypass in every controller state
            if (lock_t || tap_state == jfc_pkg::TAP_RESET)
            begin
                core_ir <= jfc_pkg::IR_BYPASS;
            end
            else if (tap_state == jfc_pkg::TAP_UPD_IR)
            begin
                core_ir <= ir_shift;
            end
        end
    end

    always_ff @(posedge tck)
    begin
        if (tck_rst)
        begin
            byp_bit <= jfc_pkg::BYP_CAPT;
        end
        else
        begin
            byp_bit <= next_byp_bit;
        end
    end

    // values the shift registers take at this edge; registered tdo leads with them
    always_comb
    begin
        next_ir_shift = ir_shift;
        next_byp_bit  = byp_bit;
        if (tap_state == jfc_pkg::TAP_CAP_IR)
        begin
            next_ir_shift = jfc_pkg::IR_CAPTURE;
        end
        else if (tap_state == jfc_pkg::TAP_SHIFT_IR)
        begin
            next_ir_shift = {tdi_pin, ir_shift[jfc_pkg::IR_W-1:1]};
        end
        if (tap_state == jfc_pkg::TAP_CAP_DR)
        begin
            next_byp_bit = jfc_pkg::BYP_CAPT;
        end
        else if (tap_state == jfc_pkg::TAP_SHIFT_DR)
        begin
            next_byp_bit = tdi_pin;
        end
    end

    assign sel_core = ~lock_t && (core_ir != jfc_pkg::IR_BYPASS);

    // ----------------------------------------------------------------
    // serial output and debug enable
    // ----------------------------------------------------------------
    always_ff @(posedge tck)
    begin
        if (tck_rst)
        begin
            tdo           <= 1'b0;
            tdo_oe        <= 1'b0;
            core_debug_en <= 1'b0;
        end
        else
        begin
            tdo_oe        <= (next_tap_state == jfc_pkg::TAP_SHIFT_DR) ||
                             (next_tap_state == jfc_pkg::TAP_SHIFT_IR);
            core_debug_en <= ~lock_t;
            if (next_tap_state == jfc_pkg::TAP_SHIFT_IR)
            begin
                tdo <= next_ir_shift[0];
            end
            else if (sel_core)
            begin
                tdo <= core_tdo;
            end
            else
            begin
                tdo <= next_byp_bit;
            end
        end
    end

endmodule

//--- tb/jfc_props.sv
/*
 * Port checks for the fuse check control block.
 * Assumes pins change between mclk edges and pin pulses span two mclk.
 */
`timescale 1ns/100ps
module jfc_props #(
    parameter int KEY_W = jfc_pkg::KEY_W
)
(
    // clocks and reset
    input wire logic                     mclk,
    input wire logic                     reset,
    input wire logic                     tck,
    // pins
    input wire logic                     tms_pin,
    input wire logic                     sense_pin,
    input wire logic                     fuse_blown_pin,
    // outputs and key inputs
    input wire logic [jfc_pkg::IR_W-1:0] core_ir,
    input wire logic                     core_debug_en,
    input wire jfc_pkg::jfc_key_req_t    key_req,
    input wire logic [KEY_W-1:0]         key_ref,
    input wire logic                     loader_grant,
    input wire jfc_pkg::jfc_status_t     status
);
    // ------------------------------------------------------------
    // tms rises since reset, and age of the end of check mode
    // ------------------------------------------------------------
    logic [1:0] rise_cnt;
    logic [2:0] end_age;

    always_ff @(posedge mclk)
    begin
        if (reset)
            rise_cnt <= 2'h0;
        else if ($rose(tms_pin) && rise_cnt != 2'h2)
            rise_cnt <= rise_cnt + 2'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            end_age <= 3'h0;
        else if (end_age != 3'h0 && end_age != 3'h7)
            end_age <= end_age + 3'h1;
        else if (end_age == 3'h0 &&
                 (($rose(tms_pin) && rise_cnt == 2'h1) || ($fell(sense_pin) && status.check_active)))
            end_age <= 3'h1;
    end

    chk_arm_first: assert property (@(posedge mclk) disable iff (reset)
        (($fell(tms_pin) || ($fell(reset) && !tms_pin)) && rise_cnt == 2'h0 && end_age == 3'h0)
        |-> ##[2:6] status.check_active) else $error("check mode not entered");
    chk_end_second: assert property (@(posedge mclk) disable iff (reset)
        $rose(tms_pin) && rise_cnt == 2'h1 |-> ##[2:6] !status.check_active) else $error("not left");
    chk_stay_done: assert property (@(posedge mclk) disable iff (reset)
        end_age > 3'h5 |-> !status.check_active && !status.sense_en) else $error("active after end");
    chk_sense_mode: assert property (@(posedge mclk) disable iff (reset)
        status.sense_en |-> status.check_active) else $error("sense on outside check mode");
    chk_sense_high: assert property (@(posedge mclk) disable iff (reset)
        tms_pin [*6] |-> !status.sense_en) else $error("sense on with tms high");
    chk_sense_end: assert property (@(posedge mclk) disable iff (reset)
        $fell(sense_pin) && status.check_active |-> ##[2:6] (!status.check_active && !status.sense_en))
        else $error("sense pin fall ignored");
    chk_fuse_lock: assert property (@(posedge mclk) disable iff (reset)
        $rose(fuse_blown_pin) |-> ##[2:6] (status.port_locked && status.mem_protect))
        else $error("fuse lock missing");
    chk_tap_bypass: assert property (@(posedge tck) disable iff (reset)
        $past(status.port_locked, 4) |-> core_ir == jfc_pkg::IR_BYPASS && !core_debug_en)
        else $error("port open while locked");
    chk_key_grant: assert property (@(posedge mclk) disable iff (reset)
        key_req.valid && key_req.key == key_ref |=> loader_grant) else $error("grant missing");
    chk_key_only: assert property (@(posedge mclk) disable iff (reset)
        loader_grant |-> $past(key_req.valid) && $past(key_req.key) == $past(key_ref))
        else $error("grant without key");
    chk_reset_clear: assert property (@(posedge mclk)
        reset |=> status == 4'h0 && !loader_grant) else $error("state kept through reset");

    cov_active: cover property (@(posedge mclk) disable iff (reset) $rose(status.check_active));
    cov_grant: cover property (@(posedge mclk) disable iff (reset) $rose(loader_grant));
    cov_lock: cover property (@(posedge mclk) disable iff (reset) $rose(status.port_locked));
endmodule

//--- tb/jfc_dbg_model.sv
/*
 * Behavioural debugger on the far side of the test link.
 * Assumes the device samples tms and tdi on rising tck and updates tdo there.
 */
`timescale 1ns/100ps
module jfc_dbg_model
(
    // toward the device
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // from the device
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    localparam int HALF = 16;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // level change with the link clock stopped
    task automatic set_tms(input logic v);
        tms = v;
    endtask

    task automatic clk1(input logic m);
        tms = m;
        #HALF tck = 1'b1;
        #HALF tck = 1'b0;
    endtask

    // reset, idle, shift n bits lsb first, update, idle
    task automatic scan(input logic ir, input int n, input logic [7:0] din,
                        output logic [7:0] dout, output logic oe_ok);
        int i;
        dout = 8'h00;
        oe_ok = 1'b1;
        repeat (5) clk1(1'b1);
        clk1(1'b0);
        clk1(1'b1);
        if (ir)
            clk1(1'b1);
        clk1(1'b0);
        clk1(1'b0);
        for (i = 0; i < n; i++)
        begin
            tdi = din[i];
            tms = (i == n - 1);
            #HALF;
            dout[i] = tdo;
            oe_ok = oe_ok & tdo_oe;
            tck = 1'b1;
            #HALF tck = 1'b0;
        end
        clk1(1'b1);
        clk1(1'b0);
        tms = 1'b1;
        tdi = ~tdi;
    endtask
endmodule

//--- tb/tb_top.sv
/*
 * Self-checking bench for the fuse check control block.
 * Assumes the debugger model drives the link and jfc_props is bound below.
 */
`timescale 1ns/100ps
module tb_top;
    localparam int KEY_W = jfc_pkg::KEY_W;
    localparam int LIMIT = 2000;

    logic                     mclk;
    logic                     reset;
    logic                     tck;
    logic                     tms_pin;
    logic                     tdi_pin;
    logic                     tdo;
    logic                     tdo_oe;
    logic                     sense_pin;
    logic                     fuse_blown_pin;
    logic                     core_debug_en;
    logic [jfc_pkg::IR_W-1:0] core_ir;
    jfc_pkg::jfc_key_req_t    key_req;
    logic [KEY_W-1:0]         key_ref;
    logic                     loader_grant;
    jfc_pkg::jfc_status_t     status;
    int                       error_cnt = 0;
    int                       n_compared = 0;
    int                       cyc_cnt = 0;

    jfc_top #(.KEY_W(KEY_W)) uut (
        .mclk(mclk), .reset(reset), .tck(tck), .tms_pin(tms_pin), .tdi_pin(tdi_pin),
        .tdo(tdo), .tdo_oe(tdo_oe), .sense_pin(sense_pin), .fuse_blown_pin(fuse_blown_pin),
        .core_tdo(1'b1), .core_debug_en(core_debug_en), .core_ir(core_ir), .key_req(key_req),
        .key_ref(key_ref), .loader_grant(loader_grant), .status(status));

    jfc_dbg_model dbg (.tck(tck), .tms(tms_pin), .tdi(tdi_pin), .tdo(tdo), .tdo_oe(tdo_oe));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT)
        begin
            error_cnt++;
            $display("timeout at %0t", $time);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_st(input logic [3:0] exp);
        check8({4'h0, status}, {4'h0, exp});
    endtask

    task automatic tms_step(input logic v, input logic [3:0] exp);
        dbg.set_tms(v);
        cyc(6);
        chk_st(exp);
    endtask

    task automatic pwr_reset(input logic lvl);
        reset = 1'b1;
        fork
            repeat (4) dbg.clk1(lvl);
            cyc(12);
        join
        reset = 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_power_low;
        pwr_reset(1'b0);
        cyc(6);
        chk_st(4'hC);
        tms_step(1'b1, 4'h8);
        tms_step(1'b0, 4'hC);
        tms_step(1'b1, 4'h0);
        tms_step(1'b0, 4'h0);
        tms_step(1'b1, 4'h0);
        $display("test_power_low done");
    endtask

    task automatic test_rearm_sense;
        sense_pin = 1'b1;
        pwr_reset(1'b1);
        tms_step(1'b0, 4'hC);
        sense_pin = 1'b0;
        cyc(6);
        chk_st(4'h0);
        tms_step(1'b1, 4'h0);
        tms_step(1'b0, 4'h0);
        tms_step(1'b1, 4'h0);
        $display("test_rearm_sense done");
    endtask

    task automatic test_tap_open;
        logic [7:0] o;
        logic       ok;
        dbg.scan(1'b1, 4, 8'h02, o, ok);
        check8(o, 8'h01);
        check8({7'h0, ok}, 8'h01);
        check8({3'h0, core_debug_en, core_ir}, 8'h12);
        $display("test_tap_open done");
    endtask

    task automatic test_fuse_lock;
        logic [7:0] o;
        logic       ok;
        fuse_blown_pin = 1'b1;
        cyc(6);
        chk_st(4'h3);
        fuse_blown_pin = 1'b0;
        cyc(6);
        chk_st(4'h3);
        dbg.scan(1'b0, 8, 8'hA5, o, ok);
        check8(o, 8'h4A);
        check8({3'h0, core_debug_en, core_ir}, 8'h0F);
        $display("test_fuse_lock done");
    endtask

    task automatic test_key;
        logic [4:0] vld;
        logic [4:0] mat;
        int         i;
        cyc(1);
        vld = 5'h0F;
        mat = 5'h16;
        for (i = 0; i < 5; i++)
        begin
            key_req.valid = vld[i];
            key_req.key = mat[i] ? key_ref : ~key_ref;
            cyc(1);
            check8({7'h0, loader_grant}, {7'h0, vld[i] & mat[i]});
        end
        $display("test_key done");
    endtask

    initial
    begin
        reset = 1'b1;
        sense_pin = 1'b0;
        fuse_blown_pin = 1'b0;
        key_req = '0;
        key_ref = {8{32'hC3A596E1}};
        test_power_low();
        test_rearm_sense();
        test_tap_open();
        test_fuse_lock();
        test_key();
        tally_and_finish();
    end
endmodule

bind jfc_top jfc_props #(.KEY_W(KEY_W)) u_props (
    .mclk(mclk), .reset(reset), .tck(tck), .tms_pin(tms_pin), .sense_pin(sense_pin),
    .fuse_blown_pin(fuse_blown_pin), .core_ir(core_ir), .core_debug_en(core_debug_en),
    .key_req(key_req), .key_ref(key_ref), .loader_grant(loader_grant), .status(status));
